// [design/swdc_regs.vh]
// Function
// - Strap picks configuration reset value 00h or 09h.
// - Firmware cycles to windows need ID nibble match.
// - Firmware BIOS enable gates firmware BIOS cycles.
// - Firmware and LPC BIOS enables reset to inverted strap level.
// - Detected host protocol rewrites both BIOS enables.
// - Flash mode maps window 1 as BIOS space.
// - Flash mode uses upper bytes and flash size.
// - Extended enable gates extended BIOS memory cycles.
// - LPC enable gates BIOS memory cycles.
// - Cycle select picks memory or firmware cycles.
// - Flash size field sizes window, ignored in RAM.
// - Memory RAM mode compares address bits 31-10.
// - Memory flash mode compares address bits 31-17.
// - Firmware RAM mode compares address bits 27-10.
// - Firmware flash mode compares address bits 27-17.
// - All-zero base disables window 1.
// - Low base bytes ignored in flash mode.
`ifndef SWDC_REGS_VH
`define SWDC_REGS_VH

// ----------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------
`define SWDC_IDX_SHARED_MEM_CONFIG 8'hf0
`define SWDC_IDX_WINDOW_CONFIG 8'hf1
`define SWDC_IDX_W1_BASE0 8'hf4
`define SWDC_IDX_W1_BASE1 8'hf5
`define SWDC_IDX_W1_BASE2 8'hf6
`define SWDC_IDX_W1_BASE3 8'hf7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SWDC_SMC_ID_HI 7
`define SWDC_SMC_ID_LO 4
`define SWDC_SMC_BIOS_FW 3
`define SWDC_SMC_FLASH 2
`define SWDC_SMC_BIOS_EXT 1
`define SWDC_SMC_BIOS_LPC 0
`define SWDC_WC_CYC_SEL 6
`define SWDC_WC_FSIZE_HI 3
`define SWDC_WC_FSIZE_LO 0
`define SWDC_WC_RW_MASK 8'h4f

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SWDC_SMC_RST_STRAP0 8'h09
`define SWDC_SMC_RST_STRAP1 8'h00
`define SWDC_WC_RST 8'h07
`define SWDC_BASE_RST 8'h00

// ----------------------------------------
// Window size: log2 of bytes is encoding plus this offset
// ----------------------------------------
`define SWDC_SIZE_LOG2_OFS 5'h0a
`define SWDC_FLASH_MIN_LOG2 5'h11
`define SWDC_MAX_LOG2 5'h1c

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define SWDC_RESP_OKAY 2'h0
`define SWDC_RESP_SLVERR 2'h2

`endif

// [design/swdc_top.v]
`timescale 1ns/10ps
`include "swdc_regs.vh"

module swdc_top (
  input wire sys_clk, // 125 MHz clock
  input wire reset, // Synchronous reset, active high
  input wire ce, // Clock enable, freezes state when low
  input wire shared_bios_strap, // Strap, 1 disables shared BIOS
  // AXI4-Lite slave
  input wire [11:0] s_axi_awaddr, // Write address
  input wire s_axi_awvalid, // Write address valid
  output wire s_axi_awready, // Write address ready
  input wire [31:0] s_axi_wdata, // Write data
  input wire [3:0] s_axi_wstrb, // Write strobes
  input wire s_axi_wvalid, // Write data valid
  output wire s_axi_wready, // Write data ready
  output wire [1:0] s_axi_bresp, // Write response
  output wire s_axi_bvalid, // Write response valid
  input wire s_axi_bready, // Write response ready
  input wire [11:0] s_axi_araddr, // Read address
  input wire s_axi_arvalid, // Read address valid
  output wire s_axi_arready, // Read address ready
  output wire [31:0] s_axi_rdata, // Read data
  output wire [1:0] s_axi_rresp, // Read response
  output wire s_axi_rvalid, // Read data valid
  input wire s_axi_rready, // Read data ready
  // Host protocol detector
  input wire proto_det_valid, // Detected protocol pulse
  input wire proto_det_fwmem, // Host uses firmware cycles for BIOS
  input wire proto_det_lpcmem, // Host uses memory cycles for BIOS
  // RAM window size from the size register outside
  input wire [3:0] ram_window_size, // RAM size encoding
  // Host cycle to decode
  input wire cyc_valid, // Cycle pulse
  input wire cyc_fw, // 1 firmware cycle, 0 memory cycle
  input wire [31:0] cyc_addr, // Cycle address
  input wire [3:0] cyc_id, // Firmware ID nibble
  input wire cyc_in_bios, // Address is in BIOS space
  input wire cyc_in_ext_bios, // Address is in extended BIOS space
  output wire claim_valid, // Decode result pulse
  output wire claim_hit, // Device claims the cycle
  output wire claim_as_bios, // Serve as BIOS flash access
  output wire claim_ram_win // Serve from internal RAM window
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] shared_mem_config_ff;
  reg [7:0] nxt_shared_mem_config;
  reg [7:0] window_config_ff;
  reg [7:0] nxt_window_config;
  reg [7:0] window1_base_byte0_ff;
  reg [7:0] nxt_window1_base_byte0;
  reg [7:0] window1_base_byte1_ff;
  reg [7:0] nxt_window1_base_byte1;
  reg [7:0] window1_base_byte2_ff;
  reg [7:0] nxt_window1_base_byte2;
  reg [7:0] window1_base_byte3_ff;
  reg [7:0] nxt_window1_base_byte3;

  reg awready_ff;
  reg wready_ff;
  reg [9:0] aw_idx_ff;
  reg aw_have_ff;
  reg [31:0] w_data_ff;
  reg w_strb0_ff;
  reg w_have_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg arready_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  reg claim_valid_ff;
  reg claim_hit_ff;
  reg claim_as_bios_ff;
  reg claim_ram_win_ff;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function is_mapped;
    input [9:0] idx;
    begin
      is_mapped = (idx == {2'h0, `SWDC_IDX_SHARED_MEM_CONFIG}) ||
                  (idx == {2'h0, `SWDC_IDX_WINDOW_CONFIG}) ||
                  (idx == {2'h0, `SWDC_IDX_W1_BASE0}) ||
                  (idx == {2'h0, `SWDC_IDX_W1_BASE1}) ||
                  (idx == {2'h0, `SWDC_IDX_W1_BASE2}) ||
                  (idx == {2'h0, `SWDC_IDX_W1_BASE3});
    end
  endfunction

  wire flash_mode;
  wire fw_mode;
  wire do_write;
  wire [9:0] ar_idx;
  reg [7:0] rd_byte;

  assign flash_mode = shared_mem_config_ff[`SWDC_SMC_FLASH];
  assign fw_mode = window_config_ff[`SWDC_WC_CYC_SEL];
  // Write commits once both halves are held and the last response is gone
  assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;
  assign ar_idx = s_axi_araddr[11:2];

  always @* begin
    case (ar_idx)
      {2'h0, `SWDC_IDX_SHARED_MEM_CONFIG}: rd_byte = shared_mem_config_ff;
      {2'h0, `SWDC_IDX_WINDOW_CONFIG}: rd_byte = window_config_ff;
      {2'h0, `SWDC_IDX_W1_BASE0}: rd_byte = window1_base_byte0_ff;
      {2'h0, `SWDC_IDX_W1_BASE1}: rd_byte = window1_base_byte1_ff;
      // Bit 0 is reserved while the window points to flash
      {2'h0, `SWDC_IDX_W1_BASE2}: rd_byte = flash_mode ? {window1_base_byte2_ff[7:1], 1'b0} : window1_base_byte2_ff;
      {2'h0, `SWDC_IDX_W1_BASE3}: rd_byte = window1_base_byte3_ff;
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Register next values
  // ----------------------------------------
  always @* begin
    nxt_shared_mem_config = shared_mem_config_ff;
    nxt_window_config = window_config_ff;
    nxt_window1_base_byte0 = window1_base_byte0_ff;
    nxt_window1_base_byte1 = window1_base_byte1_ff;
    nxt_window1_base_byte2 = window1_base_byte2_ff;
    nxt_window1_base_byte3 = window1_base_byte3_ff;
    if (do_write && w_strb0_ff) begin
      case (aw_idx_ff)
        {2'h0, `SWDC_IDX_SHARED_MEM_CONFIG}: nxt_shared_mem_config = w_data_ff[7:0];
        {2'h0, `SWDC_IDX_WINDOW_CONFIG}: nxt_window_config = w_data_ff[7:0] & `SWDC_WC_RW_MASK;
        {2'h0, `SWDC_IDX_W1_BASE0}: nxt_window1_base_byte0 = w_data_ff[7:0];
        {2'h0, `SWDC_IDX_W1_BASE1}: nxt_window1_base_byte1 = w_data_ff[7:0];
        {2'h0, `SWDC_IDX_W1_BASE2}: nxt_window1_base_byte2 = w_data_ff[7:0];
        {2'h0, `SWDC_IDX_W1_BASE3}: nxt_window1_base_byte3 = w_data_ff[7:0];
        default: nxt_shared_mem_config = shared_mem_config_ff;
      endcase
    end
    // Detector result wins over a software write in the same cycle
    if (proto_det_valid) begin
      nxt_shared_mem_config[`SWDC_SMC_BIOS_FW] = proto_det_fwmem;
      nxt_shared_mem_config[`SWDC_SMC_BIOS_LPC] = proto_det_lpcmem;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      // Strap is sampled by the clocked reset, not by an async load
      shared_mem_config_ff <= shared_bios_strap ? `SWDC_SMC_RST_STRAP1 : `SWDC_SMC_RST_STRAP0;
      window_config_ff <= `SWDC_WC_RST;
      window1_base_byte0_ff <= `SWDC_BASE_RST;
      window1_base_byte1_ff <= `SWDC_BASE_RST;
      window1_base_byte2_ff <= `SWDC_BASE_RST;
      window1_base_byte3_ff <= `SWDC_BASE_RST;
    end else if (ce) begin
      shared_mem_config_ff <= nxt_shared_mem_config;
      window_config_ff <= nxt_window_config;
      window1_base_byte0_ff <= nxt_window1_base_byte0;
      window1_base_byte1_ff <= nxt_window1_base_byte1;
      window1_base_byte2_ff <= nxt_window1_base_byte2;
      window1_base_byte3_ff <= nxt_window1_base_byte3;
    end
  end

  // ----------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (reset) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_idx_ff <= 10'h000;
      aw_have_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb0_ff <= 1'b0;
      w_have_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `SWDC_RESP_OKAY;
    end else if (ce) begin
      // Ready is offered only while the holding slot is empty
      awready_ff <= !aw_have_ff && !awready_ff && s_axi_awvalid;
      wready_ff <= !w_have_ff && !wready_ff && s_axi_wvalid;
      if (awready_ff && s_axi_awvalid) begin
        aw_idx_ff <= s_axi_awaddr[11:2];
        aw_have_ff <= 1'b1;
      end
      if (wready_ff && s_axi_wvalid) begin
        w_data_ff <= s_axi_wdata;
        w_strb0_ff <= s_axi_wstrb[0];
        w_have_ff <= 1'b1;
      end
      // The response waits for both halves, whichever order they came in
      if (do_write) begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= is_mapped(aw_idx_ff) ? `SWDC_RESP_OKAY : `SWDC_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------
  reg nxt_arready;
  reg nxt_rvalid;
  reg [31:0] nxt_rdata;
  reg [1:0] nxt_rresp;

  always @* begin
    // Ready is a one-cycle pulse, so one request is taken once only
    nxt_arready = !arready_ff && !rvalid_ff && s_axi_arvalid;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    // The address is decoded live; the master holds it until it is taken
    if (arready_ff && s_axi_arvalid) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = {24'h000000, rd_byte};
      nxt_rresp = is_mapped(ar_idx) ? `SWDC_RESP_OKAY : `SWDC_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `SWDC_RESP_OKAY;
    end else if (ce) begin
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  wire [3:0] cfg_id;
  wire bios_fw_en;
  wire bios_extended_enable;
  wire bios_lpcmem_enable;
  wire [3:0] flash_size;
  wire [31:0] win1_base;

  assign cfg_id = shared_mem_config_ff[`SWDC_SMC_ID_HI:`SWDC_SMC_ID_LO];
  assign bios_fw_en = shared_mem_config_ff[`SWDC_SMC_BIOS_FW];
  assign bios_extended_enable = shared_mem_config_ff[`SWDC_SMC_BIOS_EXT];
  assign bios_lpcmem_enable = shared_mem_config_ff[`SWDC_SMC_BIOS_LPC];
  // Size bits go out in RAM mode too; the matcher ignores them there
  assign flash_size = window_config_ff[`SWDC_WC_FSIZE_HI:`SWDC_WC_FSIZE_LO];
  assign win1_base = {window1_base_byte3_ff, window1_base_byte2_ff, window1_base_byte1_ff, window1_base_byte0_ff};

  // ----------------------------------------
  // Cycle decode
  // ----------------------------------------
  wire win1_hit;
  wire bios_hit;

  swdc_win_match u_win1 (
    .base(win1_base),
    .flash_mode(flash_mode),
    .fw_mode(fw_mode),
    .flash_size(flash_size),
    .ram_size(ram_window_size),
    .cfg_id(cfg_id),
    .cyc_fw(cyc_fw),
    .cyc_addr(cyc_addr),
    .cyc_id(cyc_id),
    .hit(win1_hit)
  );

  wire bios_fw_hit;
  wire bios_lpc_hit;
  wire bios_ext_hit;

  assign bios_fw_hit = cyc_fw && cyc_in_bios && bios_fw_en;
  assign bios_lpc_hit = !cyc_fw && cyc_in_bios && bios_lpcmem_enable;
  // The extended range answers memory cycles only
  assign bios_ext_hit = !cyc_fw && cyc_in_ext_bios && bios_extended_enable;
  assign bios_hit = bios_fw_hit || bios_lpc_hit || bios_ext_hit;

  // ----------------------------------------
  // Claim next values
  // ----------------------------------------
  reg nxt_claim_valid;
  reg nxt_claim_hit;
  reg nxt_claim_as_bios;
  reg nxt_claim_ram_win;

  always @* begin
    nxt_claim_valid = cyc_valid;
    // Claim flags stay zero whenever no cycle is decoded
    nxt_claim_hit = cyc_valid && (bios_hit || win1_hit);
    // A flash window hit is served the same way as BIOS space
    nxt_claim_as_bios = cyc_valid && (bios_hit || (win1_hit && flash_mode));
    nxt_claim_ram_win = cyc_valid && !bios_hit && win1_hit && !flash_mode;
  end

  always @(posedge sys_clk) begin
    if (reset) begin
      claim_valid_ff <= 1'b0;
      claim_hit_ff <= 1'b0;
      claim_as_bios_ff <= 1'b0;
      claim_ram_win_ff <= 1'b0;
    end else if (ce) begin
      claim_valid_ff <= nxt_claim_valid;
      claim_hit_ff <= nxt_claim_hit;
      claim_as_bios_ff <= nxt_claim_as_bios;
      claim_ram_win_ff <= nxt_claim_ram_win;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is a flop, so no decode path reaches the pins
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign claim_valid = claim_valid_ff;
  assign claim_hit = claim_hit_ff;
  assign claim_as_bios = claim_as_bios_ff;
  assign claim_ram_win = claim_ram_win_ff;

endmodule // swdc_top

// [design/swdc_win_match.v]
`timescale 1ns/10ps
`include "swdc_regs.vh"

module swdc_win_match (
  input wire [31:0] base, // Window 1 base bytes 3..0
  input wire flash_mode, // Window maps to flash
  input wire fw_mode, // Window takes firmware cycles
  input wire [3:0] flash_size, // Flash size encoding
  input wire [3:0] ram_size, // RAM size encoding
  input wire [3:0] cfg_id, // Programmed ID nibble
  input wire cyc_fw, // Cycle is a firmware cycle
  input wire [31:0] cyc_addr, // Cycle address
  input wire [3:0] cyc_id, // Cycle ID nibble
  output wire hit // Cycle falls in window 1
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [4:0] size_log2;
    input [3:0] enc;
    input [4:0] floor;
    reg [4:0] l;
    begin
      l = {1'b0, enc} + `SWDC_SIZE_LOG2_OFS;
      if (l < floor)
        l = floor;
      if (l > `SWDC_MAX_LOG2)
        l = `SWDC_MAX_LOG2;
      size_log2 = l;
    end
  endfunction

  wire [4:0] lg;
  wire [31:0] keep;
  wire [31:0] eff_base;
  wire type_ok;
  wire id_ok;
  wire enabled;

  assign lg = flash_mode ? size_log2(flash_size, `SWDC_FLASH_MIN_LOG2) : size_log2(ram_size, 5'h00);
  // Bits below the window size never take part in the compare
  assign keep = 32'hffffffff << lg;
  // Flash mode drops bytes 0..1 and byte 2 bit 0
  assign eff_base = flash_mode ? {base[31:17], 17'h00000} : base;
  assign type_ok = (cyc_fw == fw_mode);
  assign id_ok = !fw_mode || (cyc_id == cfg_id);
  assign enabled = (base != 32'h00000000);
  // Firmware cycles replace the top nibble by the ID, so bits 31-28 drop out
  assign hit = enabled && type_ok && id_ok &&
    (fw_mode ? (((cyc_addr ^ eff_base) & keep & 32'h0fffffff) == 32'h00000000)
             : (((cyc_addr ^ eff_base) & keep) == 32'h00000000));

endmodule // swdc_win_match

// [dv/swdc_asserts.sv]
`timescale 1ns/10ps
// ------------------------------
// Checker on the top ports
// ------------------------------
module swdc_asserts (
  input wire sys_clk, // Clock
  input wire reset, // Reset
  input wire ce, // Enable
  input wire s_axi_awready, // AW ready
  input wire s_axi_wready, // W ready
  input wire s_axi_arvalid, // AR valid
  input wire s_axi_arready, // AR ready
  input wire s_axi_bvalid, // B valid
  input wire s_axi_bready, // B ready
  input wire [1:0] s_axi_bresp, // B resp
  input wire s_axi_rvalid, // R valid
  input wire s_axi_rready, // R ready
  input wire [31:0] s_axi_rdata, // R data
  input wire cyc_valid, // Cycle
  input wire claim_valid, // Result
  input wire claim_hit, // Claimed
  input wire claim_as_bios, // BIOS service
  input wire claim_ram_win // RAM service
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  claim_latency_a: assert property (ce && cyc_valid |=> claim_valid) else $error("result late");
  claim_cause_a: assert property (claim_valid && $past(ce) |-> $past(cyc_valid)) else $error("stray");
  hit_idle_a: assert property (!claim_valid |-> !claim_hit) else $error("hit outside result");
  ram_win_a: assert property (claim_valid && claim_ram_win |-> claim_hit && !claim_as_bios)
    else $error("RAM service wrong");
  bios_hit_a: assert property (claim_valid && claim_as_bios |-> claim_hit) else $error("BIOS no hit");
  aw_pulse_a: assert property (s_axi_awready && ce |=> !s_axi_awready) else $error("awready long");
  w_pulse_a: assert property (s_axi_wready && ce |=> !s_axi_wready) else $error("wready long");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rvalid dropped");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid) else $error("no rvalid");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper set");
endmodule // swdc_asserts

bind swdc_top swdc_asserts swdc_asserts_i (.sys_clk, .reset, .ce, .s_axi_awready, .s_axi_wready, .s_axi_arvalid,
  .s_axi_arready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .cyc_valid,
  .claim_valid, .claim_hit, .claim_as_bios, .claim_ram_win);

// [dv/swdc_host_model.sv]
`timescale 1ns/10ps
// ------------------------------
// Host cycle source
// ------------------------------
module swdc_host_model (
  input wire sys_clk, // Clock
  output reg cyc_valid, // Pulse
  output reg cyc_fw, // Kind
  output reg [31:0] cyc_addr, // Address
  output reg [3:0] cyc_id, // ID nibble
  output reg cyc_in_bios, // BIOS space
  output reg cyc_in_ext_bios // Extended space
);
  initial begin
    {cyc_valid, cyc_fw, cyc_addr, cyc_id, cyc_in_bios, cyc_in_ext_bios} = 39'h0;
  end
  task send(input f, input [31:0] a, input [3:0] id, input ib, input ie, input [1:0] gap);
    begin
      repeat (gap + 1) @(posedge sys_clk);
      {cyc_fw, cyc_addr, cyc_id, cyc_in_bios, cyc_in_ext_bios} <= {f, a, id, ib, ie};
      cyc_valid <= 1'b1;
      @(posedge sys_clk);
      cyc_valid <= 1'b0;
      // Idle lines carry junk so a stale value is never mistaken for a cycle
      {cyc_fw, cyc_addr, cyc_id, cyc_in_bios, cyc_in_ext_bios} <= ~{f, a, id, ib, ie};
    end
  endtask
endmodule // swdc_host_model

// [dv/test_shared_window_decode_config.sv]
`timescale 1ns/10ps
module test_shared_window_decode_config;
  reg sys_clk = 1'b0;
  reg reset = 1'b1;
  reg shared_bios_strap = 1'b1;
  reg ce = 1'b1;
  reg [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'h0, ram_window_size = 4'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg proto_det_valid = 1'b0, proto_det_fwmem = 1'b0, proto_det_lpcmem = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, claim_valid, claim_hit;
  wire claim_as_bios, claim_ram_win, cyc_valid, cyc_fw, cyc_in_bios, cyc_in_ext_bios;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, cyc_addr;
  wire [3:0] cyc_id;
  reg [7:0] smc, wc, b0, b1, b2, b3;
  reg [33:0] exp_r [$];
  reg [1:0] exp_b [$];
  reg [2:0] exp_c [$];
  integer seed = 32'h0d09033e, n_errors = 0, total_checks = 0, cycles = 0, i, k;
  reg fw, ib, ie;
  reg [31:0] a;
  reg [3:0] id;

  always #4 sys_clk = ~sys_clk;

  swdc_top swdc_top_i (.sys_clk, .reset, .ce, .shared_bios_strap, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .proto_det_valid, .proto_det_fwmem, .proto_det_lpcmem, .ram_window_size, .cyc_valid, .cyc_fw,
    .cyc_addr, .cyc_id, .cyc_in_bios, .cyc_in_ext_bios, .claim_valid, .claim_hit, .claim_as_bios, .claim_ram_win);
  swdc_host_model swdc_host_model_i (.sys_clk, .cyc_valid, .cyc_fw, .cyc_addr, .cyc_id, .cyc_in_bios,
    .cyc_in_ext_bios);

  // ------------------------------
  // Reference model
  // ------------------------------
  function automatic [33:0] ref_rd(input [7:0] idx);
    case (idx)
      8'hf0: ref_rd = {26'h0, smc};
      8'hf1: ref_rd = {26'h0, wc};
      8'hf4: ref_rd = {26'h0, b0};
      8'hf5: ref_rd = {26'h0, b1};
      8'hf6: ref_rd = {26'h0, b2[7:1], b2[0] & !smc[2]};
      8'hf7: ref_rd = {26'h0, b3};
      default: ref_rd = {2'h2, 32'h0};
    endcase
  endfunction

  function automatic [2:0] ref_claim(input f, input [31:0] ad, input [3:0] cid, input bi, input ei);
    reg bh, wh;
    reg [31:0] m;
    begin
      bh = bi && (f ? smc[3] : smc[0]) || !f && ei && smc[1];
      m = smc[2] ? 32'hffffffff << ((wc[3:0] > 4'h7) ? wc[3:0] + 5'd10 : 5'd17) :
        32'hffffffff << (ram_window_size + 5'd10);
      if (f) m[31:28] = 4'h0;
      wh = {b3, b2, b1, b0} != 32'h0 && f == wc[6] && (!f || cid == smc[7:4]) && (((ad ^ {b3, b2, b1, b0}) & m) == 32'h0);
      ref_claim = {bh || wh, bh || wh && smc[2], wh && !smc[2] && !bh};
    end
  endfunction

  // ------------------------------
  // Drivers and checking
  // ------------------------------
  task note(input ok, input string what);
    begin
      total_checks = total_checks + 1;
      if (!ok) begin
        n_errors = n_errors + 1;
        $display("MISMATCH at %0t: %s differs", $time, what);
      end
    end
  endtask
  task cmp_rd(input [33:0] got, input [33:0] exp); note(got === exp, "read"); endtask
  task cmp_wr(input [1:0] got, input [1:0] exp); note(got === exp, "write response"); endtask
  task cmp_claim(input [2:0] got, input [2:0] exp); note(got === exp, "claim"); endtask

  task results;
    begin
      if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask

  task do_reset(input s);
    begin
      shared_bios_strap <= s;
      reset <= 1'b1;
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      smc = s ? 8'h00 : 8'h09;
      wc = 8'h07;
      {b3, b2, b1, b0} = 32'h0;
    end
  endtask

  task axi_wr(input [7:0] idx, input [7:0] d);
    reg [33:0] r;
    begin
      r = ref_rd(idx);
      exp_b.push_back(r[33:32]);
      @(posedge sys_clk);
      s_axi_awaddr <= {2'h0, idx, 2'h0};
      s_axi_wdata <= (32'($random(seed)) << 8) | {24'h0, d};
      s_axi_wstrb <= 4'h1 | 4'($random(seed));
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
        @(posedge sys_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      case (idx)
        8'hf0: smc = d;
        8'hf1: wc = d & 8'h4f;
        8'hf4: b0 = d;
        8'hf5: b1 = d;
        8'hf6: b2 = d;
        8'hf7: b3 = d;
        default: ;
      endcase
    end
  endtask

  task axi_rd(input [7:0] idx);
    begin
      exp_r.push_back(ref_rd(idx));
      @(posedge sys_clk);
      s_axi_araddr <= {2'h0, idx, 2'h0};
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
        @(posedge sys_clk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
    end
  endtask

  task det(input f, input l);
    begin
      @(posedge sys_clk);
      {proto_det_valid, proto_det_fwmem, proto_det_lpcmem} <= {1'b1, f, l};
      @(posedge sys_clk);
      proto_det_valid <= 1'b0;
      smc[3] = f;
      smc[0] = l;
    end
  endtask

  always @(posedge sys_clk) begin
    if (s_axi_rvalid && s_axi_rready) cmp_rd({s_axi_rresp, s_axi_rdata}, exp_r.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp_wr(s_axi_bresp, exp_b.pop_front());
    if (claim_valid) cmp_claim({claim_hit, claim_as_bios, claim_ram_win}, exp_c.pop_front());
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      results;
    end
  end

  initial begin
    do_reset(1'b1);
    for (i = 240; i < 248; i++) axi_rd(i[7:0]);
    axi_wr(8'hf3, 8'h5a);
    axi_rd(8'hf0);
    do_reset(1'b0);
    axi_rd(8'hf0);
    axi_wr(8'hf1, 8'hff);
    axi_rd(8'hf1);
    det(1'b0, 1'b1);
    axi_rd(8'hf0);
    // A detector pulse while the enable is low must leave the register alone
    @(posedge sys_clk);
    {ce, proto_det_valid, proto_det_fwmem, proto_det_lpcmem} <= {2'h1, ~smc[3], ~smc[0]};
    @(posedge sys_clk);
    {ce, proto_det_valid} <= 2'h2;
    axi_rd(8'hf0);
    for (k = 0; k < 40; k++) begin
      axi_wr(8'hf0, 8'($random(seed)));
      axi_wr(8'hf1, 8'($random(seed)));
      ram_window_size <= 4'($random(seed));
      for (i = 244; i < 248; i++) axi_wr(i[7:0], (k % 5 == 1) ? 8'h0 : 8'($random(seed)));
      axi_rd(8'hf6);
      if (k % 4 == 0) det(1'($random(seed)), 1'($random(seed)));
      repeat (8) begin
        fw = 1'($random(seed));
        {ib, ie} = 2'($random(seed));
        id = (1'($random(seed))) ? smc[7:4] : 4'($random(seed));
        // Window traffic stays clear of BIOS space; BIOS cycles take random addresses and can still hit the window
        a = (ib || ie) ? 32'($random(seed)) : {b3, b2, b1, b0} ^ (32'($random(seed)) >> (4 + {$random(seed)} % 28));
        exp_c.push_back(ref_claim(fw, a, id, ib, ie));
        swdc_host_model_i.send(fw, a, id, ib, ie, 2'($random(seed)));
      end
    end
    repeat (4) @(posedge sys_clk);
    note(exp_c.size() + exp_r.size() + exp_b.size() == 0, "result count");
    results;
  end
endmodule // test_shared_window_decode_config
